// [pscmd_pkg.sv]
// Shared constants and types for the scratch-pad command link.
// Assumes one 16-bit word per link transfer and one clock for both ends.
package pscmd_pkg;
    localparam int WORD_W     = 16;
    localparam int N_TC       = 8;
    localparam int TC_IDX_W   = 3;
    localparam int HDR_WORDS  = 6;
    localparam int SP_WORDS   = 5;
    localparam int HREG_N     = 16;
    localparam int HREG_IDX_W = 4;

    typedef logic [WORD_W-1:0] pscmd_word_t;

    // Command numbers, 6111 and 6101 decimal
    localparam pscmd_word_t CMD_WRITE = 16'h17df;
    localparam pscmd_word_t CMD_READ  = 16'h17d5;
    // Memory types
    localparam pscmd_word_t MEM_REG     = 16'h0001;
    localparam pscmd_word_t MEM_SCRATCH = 16'h0006;
    // Scratch-pad locations
    localparam pscmd_word_t SP_CMD_ADDR    = 16'h0002;
    localparam pscmd_word_t SP_RESULT_ADDR = 16'h0004;
    localparam logic [WORD_W:0] SP_END     = 17'h00007;
    localparam int          SP_PW_IDX      = 4;
    // Subcodes in the command word
    localparam pscmd_word_t SUB_LOGIN  = 16'h0900;
    localparam pscmd_word_t SUB_PWCHG  = 16'h0a00;
    localparam pscmd_word_t SUB_ERRCHK = 16'h0300;
    localparam pscmd_word_t SUB_ERRLOC = 16'h0600;
    // Accumulators start at register address 1
    localparam pscmd_word_t     TC_BASE_ADDR = 16'h0001;
    localparam logic [WORD_W:0] TC_END       = 17'h00009;
    // Header word positions
    localparam int HDR_CMD  = 0;
    localparam int HDR_ID   = 1;
    localparam int HDR_MEM  = 2;
    localparam int HDR_ADDR = 3;
    localparam int HDR_LEN  = 4;
    localparam int HDR_SRC  = 5;
    localparam pscmd_word_t HDR_LAST  = 16'h0005;
    localparam pscmd_word_t WORD_ZERO = 16'h0000;
    localparam pscmd_word_t WORD_ONE  = 16'h0001;
    localparam pscmd_word_t PW_RESET  = 16'h0000;

    typedef enum logic [1:0] {D_HDR, D_WDATA, D_RDATA, D_DONE} pscmd_dstate_t;
    typedef enum logic [1:0] {H_IDLE, H_HDR, H_DATA, H_WAIT} pscmd_hstate_t;
endpackage

// [pscmd_link_if.sv]
// Word link between the requesting host end and the target device end.
// Assumes both ends share core_clk_i; no back-pressure, one word a cycle.
`timescale 1ns/100ps
interface pscmd_link_if;
    logic                  h2d_valid;
    pscmd_pkg::pscmd_word_t h2d_word;
    logic                  d2h_valid;
    pscmd_pkg::pscmd_word_t d2h_word;
    logic                  d2h_done;
    logic                  d2h_ok;

    modport dev  (input  h2d_valid, h2d_word,
                  output d2h_valid, d2h_word, d2h_done, d2h_ok);
    modport host (output h2d_valid, h2d_word,
                  input  d2h_valid, d2h_word, d2h_done, d2h_ok);
endinterface

// [pscmd_device.sv]
// Target end: decodes request blocks, timer/counter accumulators,
// scratch-pad password and program-error commands.
// Assumes user-logic inputs are synchronous to core_clk_i.
`timescale 1ns/100ps
module pscmd_device (
    input  wire logic                                        core_clk_i,
    input  wire logic                                        reset_i,
    pscmd_link_if.dev                                        link,
    input  wire pscmd_pkg::pscmd_word_t                      station_id_i,
    input  wire logic                                        tick_i,
    input  wire logic [pscmd_pkg::N_TC-1:0]                  tc_used_i,
    input  wire logic [pscmd_pkg::N_TC-1:0]                  tc_timer_i,
    input  wire logic [pscmd_pkg::N_TC-1:0]                  tc_in_i,
    input  wire logic [pscmd_pkg::N_TC-1:0]                  tc_reset_i,
    input  wire pscmd_pkg::pscmd_word_t [pscmd_pkg::N_TC-1:0] tc_preset_i,
    input  wire pscmd_pkg::pscmd_word_t                      err_code_i,
    input  wire pscmd_pkg::pscmd_word_t                      err_addr_i,
    output pscmd_pkg::pscmd_word_t [pscmd_pkg::N_TC-1:0]     tc_acc_o,
    output logic [pscmd_pkg::N_TC-1:0]                       tc_done_o,
    output logic                                             logged_in_o,
    output logic                                             pw_set_o
);
    import pscmd_pkg::*;

    function automatic logic [TC_IDX_W-1:0] tc_idx(input pscmd_word_t a);
        pscmd_word_t d;
        d = a - TC_BASE_ADDR;
        return d[TC_IDX_W-1:0];
    endfunction

    pscmd_dstate_t            state_reg;
    pscmd_dstate_t            state_next;
    pscmd_word_t              cnt_reg;
    pscmd_word_t              cnt_next;
    pscmd_word_t              hdr_reg [HDR_WORDS];
    logic                     ok_reg;
    pscmd_word_t [N_TC-1:0]   acc_reg;
    pscmd_word_t [N_TC-1:0]   acc_next;
    logic [N_TC-1:0]          done_reg;
    pscmd_word_t              sp_reg [SP_WORDS];
    pscmd_word_t              pw_reg;
    logic                     pw_set_reg;
    logic                     login_reg;
    pscmd_word_t              result_reg;
    logic                     d2h_valid_reg;
    pscmd_word_t              d2h_word_reg;
    logic                     d2h_done_reg;
    logic                     d2h_ok_reg;

    // Header decode
    wire pscmd_word_t      h_cmd   = hdr_reg[HDR_CMD];
    wire pscmd_word_t      h_mem   = hdr_reg[HDR_MEM];
    wire pscmd_word_t      h_addr  = hdr_reg[HDR_ADDR];
    wire pscmd_word_t      h_len   = hdr_reg[HDR_LEN];
    wire logic             is_wr   = (h_cmd == CMD_WRITE);
    wire logic             is_rd   = (h_cmd == CMD_READ);
    wire logic             mem_reg = (h_mem == MEM_REG);
    wire logic             mem_sp  = (h_mem == MEM_SCRATCH);
    wire logic [WORD_W:0]  h_end   = {1'b0, h_addr} + {1'b0, h_len};
    wire logic             len_ok  = (h_len != WORD_ZERO);
    wire logic             reg_ok  = mem_reg && (h_addr >= TC_BASE_ADDR)
                                     && (h_end <= TC_END);
    wire logic             sp_ok   = mem_sp && (h_end <= SP_END);
    wire logic             req_ok  = (is_wr || is_rd) && len_ok
                                     && (hdr_reg[HDR_ID] == station_id_i)
                                     && (reg_ok || sp_ok);

    // Word sequencing
    wire logic hdr_in  = (state_reg == D_HDR) && link.h2d_valid;
    wire logic data_in = (state_reg == D_WDATA) && link.h2d_valid;
    wire logic step    = hdr_in || data_in || (state_reg == D_RDATA);
    wire logic at_last = (state_reg == D_HDR) ? (cnt_reg == HDR_LAST)
                                              : (cnt_reg == h_len - WORD_ONE);
    wire pscmd_word_t cur_addr = h_addr + cnt_reg;
    wire pscmd_word_t sp_off   = cur_addr - SP_CMD_ADDR;

    // Write strobes; rejected requests still swallow their data words
    wire logic acc_wr = data_in && ok_reg && mem_reg;
    wire logic sp_wr  = data_in && ok_reg && mem_sp
                        && (cur_addr >= SP_CMD_ADDR);
    wire logic [TC_IDX_W-1:0] wr_idx = tc_idx(cur_addr);

    // Read word; 16-bit accumulator goes out whole, low byte low
    wire pscmd_word_t rd_word = mem_reg ? acc_reg[tc_idx(cur_addr)]
                              : (cur_addr == SP_RESULT_ADDR) ? result_reg
                              : WORD_ZERO;

    // Scratch-pad command executes once the whole write has landed
    wire logic cmd_exec = (state_reg == D_DONE) && ok_reg && is_wr && mem_sp
                          && (h_addr == SP_CMD_ADDR);
    wire pscmd_word_t sub  = sp_reg[0];
    wire pscmd_word_t pw_w = sp_reg[SP_PW_IDX];
    wire logic pw_match  = (pw_w == pw_reg);
    wire logic chg_allow = !pw_set_reg || login_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next   = step ? (at_last ? WORD_ZERO : cnt_reg + WORD_ONE)
                          : cnt_reg;
        case (state_reg)
            D_HDR: begin
                if (hdr_in && at_last) begin
                    if (is_wr && len_ok)
                        state_next = D_WDATA;
                    else if (req_ok)
                        state_next = D_RDATA;
                    else
                        state_next = D_DONE;
                end
            end
            D_WDATA: begin
                if (data_in && at_last)
                    state_next = D_DONE;
            end
            D_RDATA: begin
                if (at_last)
                    state_next = D_DONE;
            end
            D_DONE:  state_next = D_HDR;
            default: state_next = D_HDR;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= D_HDR;
            cnt_reg   <= WORD_ZERO;
            ok_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if (hdr_in && at_last)
                ok_reg <= req_ok;
        end
    end

    // Header words and scratch-pad buffer need no reset
    always_ff @(posedge core_clk_i) begin
        if (hdr_in)
            hdr_reg[cnt_reg[2:0]] <= link.h2d_word;
        if (sp_wr)
            sp_reg[sp_off[2:0]] <= link.h2d_word;
    end

    // Password, log-in and error result
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pw_reg     <= PW_RESET;
            pw_set_reg <= 1'b0;
            login_reg  <= 1'b0;
            result_reg <= WORD_ZERO;
        end else if (cmd_exec) begin
            case (sub)
                SUB_LOGIN: begin
                    login_reg <= pw_match;
                end
                SUB_PWCHG: begin
                    if (chg_allow) begin
                        pw_reg     <= pw_w;
                        pw_set_reg <= 1'b1;
                    end
                end
                SUB_ERRCHK: begin
                    result_reg <= err_code_i;
                end
                SUB_ERRLOC: begin
                    result_reg <= err_addr_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Accumulator behaviour per timer or counter
    genvar gi;
    generate
        for (gi = 0; gi < N_TC; gi++) begin : g_tc
            wire logic hit   = acc_wr && (wr_idx == gi);
            wire logic below = (acc_reg[gi] < tc_preset_i[gi]);
            wire logic adv   = tc_timer_i[gi] ? tick_i : tc_in_i[gi];
            always_comb begin
                acc_next[gi] = acc_reg[gi];
                if (!tc_used_i[gi]) begin
                    if (hit)
                        acc_next[gi] = link.h2d_word;
                end else if (tc_reset_i[gi]) begin
                    acc_next[gi] = WORD_ZERO;
                end else if (tc_timer_i[gi] && !tc_in_i[gi]) begin
                    acc_next[gi] = WORD_ZERO;
                end else if (hit) begin
                    // Below preset this also drops the done bit
                    acc_next[gi] = link.h2d_word;
                end else if (below && adv) begin
                    acc_next[gi] = acc_reg[gi] + WORD_ONE;
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    acc_reg[gi]  <= WORD_ZERO;
                    done_reg[gi] <= 1'b0;
                end else begin
                    acc_reg[gi]  <= acc_next[gi];
                    done_reg[gi] <= tc_used_i[gi]
                                    && (acc_next[gi] >= tc_preset_i[gi]);
                end
            end
        end
    endgenerate

    // Link answer
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            d2h_valid_reg <= 1'b0;
            d2h_word_reg  <= WORD_ZERO;
            d2h_done_reg  <= 1'b0;
            d2h_ok_reg    <= 1'b0;
        end else begin
            d2h_valid_reg <= (state_reg == D_RDATA);
            d2h_word_reg  <= (state_reg == D_RDATA) ? rd_word : WORD_ZERO;
            d2h_done_reg  <= (state_reg == D_DONE);
            d2h_ok_reg    <= (state_reg == D_DONE) && ok_reg;
        end
    end

    assign link.d2h_valid = d2h_valid_reg;
    assign link.d2h_word  = d2h_word_reg;
    assign link.d2h_done  = d2h_done_reg;
    assign link.d2h_ok    = d2h_ok_reg;
    assign tc_acc_o       = acc_reg;
    assign tc_done_o      = done_reg;
    assign logged_in_o    = login_reg;
    assign pw_set_o       = pw_set_reg;
endmodule

// [pscmd_host.sv]
// Requesting end: sends one request block and moves words between its
// own register table and the target. Assumes one request at a time.
`timescale 1ns/100ps
module pscmd_host (
    input  wire logic                              core_clk_i,
    input  wire logic                              reset_i,
    pscmd_link_if.host                             link,
    input  wire logic                              start_i,
    input  wire pscmd_pkg::pscmd_word_t            cmd_i,
    input  wire pscmd_pkg::pscmd_word_t            id_i,
    input  wire pscmd_pkg::pscmd_word_t            mem_i,
    input  wire pscmd_pkg::pscmd_word_t            addr_i,
    input  wire pscmd_pkg::pscmd_word_t            len_i,
    input  wire pscmd_pkg::pscmd_word_t            src_i,
    input  wire logic                              reg_wr_i,
    input  wire logic [pscmd_pkg::HREG_IDX_W-1:0]  reg_widx_i,
    input  wire pscmd_pkg::pscmd_word_t            reg_wdata_i,
    input  wire logic [pscmd_pkg::HREG_IDX_W-1:0]  reg_ridx_i,
    output pscmd_pkg::pscmd_word_t                 reg_rdata_o,
    output logic                                   busy_o,
    output logic                                   done_o,
    output logic                                   ok_o
);
    import pscmd_pkg::*;

    pscmd_hstate_t state_reg;
    pscmd_word_t   cnt_reg;
    pscmd_word_t   hdr_reg [HDR_WORDS];
    pscmd_word_t   regs_reg [HREG_N];
    logic          h2d_valid_reg;
    pscmd_word_t   h2d_word_reg;
    pscmd_word_t   rdata_reg;
    logic          done_reg;
    logic          ok_reg;
    logic          busy_reg;

    wire pscmd_word_t h_len   = hdr_reg[HDR_LEN];
    wire pscmd_word_t r_addr  = hdr_reg[HDR_SRC] - WORD_ONE + cnt_reg;
    wire logic [HREG_IDX_W-1:0] r_idx = r_addr[HREG_IDX_W-1:0];
    wire logic        is_wr   = (hdr_reg[HDR_CMD] == CMD_WRITE);
    wire logic        hdr_end = (cnt_reg == HDR_LAST);
    wire logic        dat_end = (cnt_reg == h_len - WORD_ONE);
    wire logic        take    = (state_reg == H_WAIT) && link.d2h_valid;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg     <= H_IDLE;
            cnt_reg       <= WORD_ZERO;
            h2d_valid_reg <= 1'b0;
            h2d_word_reg  <= WORD_ZERO;
            done_reg      <= 1'b0;
            ok_reg        <= 1'b0;
            busy_reg      <= 1'b0;
        end else begin
            h2d_valid_reg <= 1'b0;
            h2d_word_reg  <= WORD_ZERO;
            done_reg      <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    cnt_reg <= WORD_ZERO;
                    if (start_i) begin
                        state_reg <= H_HDR;
                        busy_reg  <= 1'b1;
                    end
                end
                H_HDR: begin
                    h2d_valid_reg <= 1'b1;
                    h2d_word_reg  <= hdr_reg[cnt_reg[2:0]];
                    cnt_reg       <= hdr_end ? WORD_ZERO
                                             : cnt_reg + WORD_ONE;
                    if (hdr_end)
                        state_reg <= (is_wr && h_len != WORD_ZERO)
                                     ? H_DATA : H_WAIT;
                end
                H_DATA: begin
                    h2d_valid_reg <= 1'b1;
                    h2d_word_reg  <= regs_reg[r_idx];
                    cnt_reg       <= dat_end ? WORD_ZERO
                                             : cnt_reg + WORD_ONE;
                    if (dat_end)
                        state_reg <= H_WAIT;
                end
                H_WAIT: begin
                    if (take)
                        cnt_reg <= cnt_reg + WORD_ONE;
                    if (link.d2h_done) begin
                        done_reg  <= 1'b1;
                        ok_reg    <= link.d2h_ok;
                        state_reg <= H_IDLE;
                        busy_reg  <= 1'b0;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    // Request block latched at start; caller picks 06111 or 06101
    always_ff @(posedge core_clk_i) begin
        if ((state_reg == H_IDLE) && start_i) begin
            hdr_reg[HDR_CMD]  <= cmd_i;
            hdr_reg[HDR_ID]   <= id_i;
            hdr_reg[HDR_MEM]  <= mem_i;
            hdr_reg[HDR_ADDR] <= addr_i;
            hdr_reg[HDR_LEN]  <= len_i;
            hdr_reg[HDR_SRC]  <= src_i;
        end
    end

    // Returned words win over any user write in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (take)
            regs_reg[r_idx] <= link.d2h_word;
        else if (reg_wr_i)
            regs_reg[reg_widx_i] <= reg_wdata_i;
        rdata_reg <= regs_reg[reg_ridx_i];
    end

    assign link.h2d_valid = h2d_valid_reg;
    assign link.h2d_word  = h2d_word_reg;
    assign reg_rdata_o    = rdata_reg;
    assign busy_o         = busy_reg;
    assign done_o         = done_reg;
    assign ok_o           = ok_reg;
endmodule

// [pscmd_assertions.sv]
// Link checker for the scratch-pad command link.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module pscmd_assertions (
    input wire logic                   core_clk_i,
    input wire logic                   reset_i,
    input wire logic                   h2d_valid,
    input wire pscmd_pkg::pscmd_word_t h2d_word,
    input wire logic                   d2h_valid,
    input wire pscmd_pkg::pscmd_word_t d2h_word,
    input wire logic                   d2h_done,
    input wire logic                   d2h_ok
);
    import pscmd_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    AST_HDR_SIX: assert property (
        $rose(h2d_valid) |-> h2d_valid [*6])
        else $error("request header shorter than six words");
    AST_CMD_FIRST: assert property (
        $rose(h2d_valid) |-> h2d_word == CMD_WRITE || h2d_word == CMD_READ)
        else $error("request does not open with a command number");
    AST_H2D_IDLE: assert property (
        !h2d_valid |-> h2d_word == WORD_ZERO)
        else $error("host word not zero while idle");
    AST_D2H_IDLE: assert property (
        !d2h_valid |-> d2h_word == WORD_ZERO)
        else $error("device word not zero while idle");
    AST_DONE_PULSE: assert property (
        d2h_done |=> !d2h_done)
        else $error("done longer than one cycle");
    AST_OK_WITH_DONE: assert property (
        d2h_ok |-> d2h_done)
        else $error("ok without done");
    AST_ANSWER: assert property (
        $fell(h2d_valid) |-> ##1 (d2h_done || d2h_valid))
        else $error("no answer two cycles after last host word");
    AST_READ_END: assert property (
        d2h_valid ##1 !d2h_valid |-> d2h_done)
        else $error("read-out not closed by done");
    AST_NO_TALK: assert property (
        d2h_valid |-> !h2d_valid)
        else $error("host word during read-out");
    AST_QUIET_AFTER: assert property (
        d2h_done |=> !h2d_valid [*2])
        else $error("host word too soon after done");

    COV_READ: cover property (d2h_valid ##1 d2h_done);
    COV_OK: cover property (d2h_done && d2h_ok);
    COV_REFUSE: cover property (d2h_done && !d2h_ok);
endmodule

// [testbench.sv]
// Host and device ends joined over the link, driven from their user sides.
// Assumes the package, interface, design ends and checker come first.
`timescale 1ns/100ps
module testbench;
    import pscmd_pkg::*;
    localparam pscmd_word_t ST = 16'h0002;
    logic                   core_clk_i, reset_i, start_i, reg_wr_i, tick_i;
    logic [3:0]             reg_widx_i, reg_ridx_i;
    pscmd_word_t            cmd_i, id_i, mem_i, addr_i, len_i, src_i;
    pscmd_word_t            reg_wdata_i, reg_rdata_o, err_code_i, err_addr_i;
    logic [N_TC-1:0]        tc_used_i, tc_timer_i, tc_in_i, tc_reset_i;
    logic [N_TC-1:0]        tc_done_o;
    pscmd_word_t [N_TC-1:0] tc_preset_i, tc_acc_o;
    logic                   busy_o, done_o, ok_o, logged_in_o, pw_set_o;
    int                     failures, checks_done;
    logic [15:0]            exp_q[$];
    pscmd_word_t            ea[8];
    pscmd_word_t            rd;
    logic [15:0]            exp_ok;

    pscmd_link_if link ();
    pscmd_device pscmd_device_inst (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .link(link), .station_id_i(ST), .tick_i(tick_i),
        .tc_used_i(tc_used_i), .tc_timer_i(tc_timer_i), .tc_in_i(tc_in_i),
        .tc_reset_i(tc_reset_i), .tc_preset_i(tc_preset_i),
        .err_code_i(err_code_i), .err_addr_i(err_addr_i),
        .tc_acc_o(tc_acc_o), .tc_done_o(tc_done_o),
        .logged_in_o(logged_in_o), .pw_set_o(pw_set_o));
    pscmd_host pscmd_host_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .link(link), .start_i(start_i), .cmd_i(cmd_i), .id_i(id_i),
        .mem_i(mem_i), .addr_i(addr_i), .len_i(len_i), .src_i(src_i),
        .reg_wr_i(reg_wr_i), .reg_widx_i(reg_widx_i),
        .reg_wdata_i(reg_wdata_i), .reg_ridx_i(reg_ridx_i),
        .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .done_o(done_o),
        .ok_o(ok_o));
    pscmd_assertions pscmd_assertions_inst (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .h2d_valid(link.h2d_valid),
        .h2d_word(link.h2d_word), .d2h_valid(link.d2h_valid),
        .d2h_word(link.d2h_word), .d2h_done(link.d2h_done),
        .d2h_ok(link.d2h_ok));

    initial begin
        core_clk_i = 0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr_reg(input int i, input pscmd_word_t d);
        reg_wr_i = 1'b1;
        reg_widx_i = 4'(i);
        reg_wdata_i = d;
        step(1);
        // Edge between writes, so the strobe never toggles in one step
        reg_wr_i = 1'b0;
        step(1);
    endtask
    task automatic rd_reg(input int i, output pscmd_word_t d);
        reg_ridx_i = 4'(i);
        step(1);
        d = reg_rdata_o;
    endtask
    // Expected ok is queued before start; the monitor pops it at done
    task automatic req(input pscmd_word_t c, d, m, a, l, s, input logic ok);
        cmd_i = c;
        id_i = d;
        mem_i = m;
        addr_i = a;
        len_i = l;
        src_i = s;
        exp_q.push_back({15'h0000, ok});
        start_i = 1'b1;
        step(1);
        start_i = 1'b0;
        cmp({15'h0000, busy_o}, 16'h0001);
        for (int k = 0; k < 200 && done_o !== 1'b1; k++) step(1);
        step(1);
        cmp({15'h0000, busy_o}, 16'h0000);
    endtask
    // Refused write; the target must still swallow its data words
    task automatic rej(input pscmd_word_t d, m, a, l);
        req(CMD_WRITE, d, m, a, l, 16'h5, 1'b0);
    endtask
    task automatic sp_rw(input pscmd_word_t c, a, s);
        req(c, ST, MEM_SCRATCH, a, 16'h1, s, 1'b1);
    endtask
    task automatic sp_cmd(input pscmd_word_t w0, w4);
        wr_reg(0, w0);
        for (int i = 1; i < 4; i++) wr_reg(i, WORD_ZERO);
        wr_reg(4, w4);
        req(CMD_WRITE, ST, MEM_SCRATCH, SP_CMD_ADDR, 16'h5, 16'h1, 1'b1);
    endtask
    task automatic chk_acc;
        for (int i = 0; i < 8; i++)
            cmp(tc_acc_o[i], ea[i]);
    endtask

    always @(posedge core_clk_i) begin
        if (!reset_i && done_o === 1'b1) begin
            exp_ok = exp_q.size() ? exp_q.pop_front() : 16'hdead;
            cmp({15'h0000, ok_o}, exp_ok);
        end
    end

    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        {reset_i, start_i, reg_wr_i, tick_i} = 4'h9;
        {reg_widx_i, reg_ridx_i, cmd_i, id_i, mem_i, addr_i} = '0;
        {len_i, src_i, reg_wdata_i, err_code_i, err_addr_i} = '0;
        failures = 0;
        checks_done = 0;
        // Unit 0 free; 1,2,3,6 timers; 3 and 4 held in reset
        tc_used_i = 8'hfe;
        tc_timer_i = 8'h4e;
        tc_in_i = 8'h4c;
        tc_reset_i = 8'h18;
        for (int i = 0; i < 8; i++) tc_preset_i[i] = 16'hffff;
        tc_preset_i[6] = 16'h0003;
        tc_preset_i[7] = 16'h0002;
        void'($urandom(12440));
        step(6);
        reset_i = 0;
        tick_i = 1;
        tc_in_i = 8'hcc;
        step(2);
        tc_in_i = 8'h4c;
        step(1);
        tick_i = 0;
        step(2);
        cmp({14'h0000, tc_done_o[7:6]}, 16'h0003);
        ea = '{16'($urandom), 16'h1234, 16'($urandom) & 16'h7fff, 16'h00ff,
               16'hff00, 16'($urandom) & 16'h7fff, 16'h0001, 16'h0001};
        for (int i = 0; i < 8; i++) wr_reg(i, ea[i]);
        req(CMD_WRITE, ST, MEM_REG, 16'h1, 16'h8, 16'h1, 1'b1);
        ea[1] = 16'h0000;
        ea[3] = 16'h0000;
        ea[4] = 16'h0000;
        chk_acc();
        cmp({14'h0000, tc_done_o[7:6]}, 16'h0000);
        tick_i = 1;
        tc_in_i = 8'hec;
        step(1);
        tc_in_i = 8'h4c;
        step(1);
        tick_i = 0;
        step(2);
        ea[2] += 16'h0002;
        ea[5] += 16'h0001;
        ea[6] = 16'h0003;
        ea[7] = 16'h0002;
        chk_acc();
        // Refused writes still consume their words and change nothing
        rej(16'h3, MEM_REG, 16'h1, 16'h1);
        rej(ST, 16'h3, 16'h1, 16'h1);
        rej(ST, MEM_REG, 16'h9, 16'h1);
        rej(ST, MEM_REG, 16'h8, 16'h2);
        rej(ST, MEM_REG, 16'h1, 16'h0);
        rej(ST, MEM_SCRATCH, 16'h6, 16'h2);
        chk_acc();
        req(CMD_READ, ST, MEM_REG, 16'h1, 16'h8, 16'h9, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rd_reg(8 + i, rd);
            cmp(rd, ea[i]);
        end
        sp_cmd(SUB_PWCHG, 16'h0100);
        cmp({14'h0000, pw_set_o, logged_in_o}, 16'h0002);
        sp_cmd(SUB_LOGIN, 16'h0101);
        cmp({15'h0000, logged_in_o}, 16'h0000);
        // Change while not logged in must be ignored; next log-in proves it
        sp_cmd(SUB_PWCHG, 16'h0200);
        sp_cmd(SUB_LOGIN, 16'h0100);
        cmp({15'h0000, logged_in_o}, 16'h0001);
        for (int j = 0; j < 2; j++) begin
            err_code_i = j ? 16'($urandom) | 16'h0001 : WORD_ZERO;
            err_addr_i = 16'($urandom);
            wr_reg(0, SUB_ERRCHK);
            sp_rw(CMD_WRITE, SP_CMD_ADDR, 16'h1);
            sp_rw(CMD_READ, SP_RESULT_ADDR, 16'h2);
            rd_reg(1, rd);
            cmp(rd, err_code_i);
            // Location check only once the code read back is nonzero
            if (rd !== WORD_ZERO) begin
                wr_reg(2, SUB_ERRLOC);
                sp_rw(CMD_WRITE, SP_CMD_ADDR, 16'h3);
                sp_rw(CMD_READ, SP_RESULT_ADDR, 16'h4);
                rd_reg(3, rd);
                cmp(rd, err_addr_i);
            end
        end
        step(2);
        cmp(16'(exp_q.size()), 16'h0000);
        complete_run();
    end
endmodule
